//--- bench/rate_detect_chk.sv
`timescale 1ns/1ps
`default_nettype none
module rate_detect_chk
   import rate_detect_pkg::*;
(
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        serial_in_line,
   input wire logic [7:0]  rx_data,
   input wire logic        receive_flag,
   input wire logic        receiver_hold
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   a_rdy_wait: assert property (psel && penable && !pready |=> pready)
      else $error("no answer after one wait");
   a_rdy_pulse: assert property (pready |=> !pready)
      else $error("pready wider than one cycle");
   a_rdy_access: assert property (pready |-> psel && penable)
      else $error("pready outside access");
   a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("bad refusal");
   a_hold_set: assert property (pready && pwrite && !pslverr && paddr == ADDR_CONTROL && pwdata[0] |=> receiver_hold)
      else $error("receiver not held");
   a_read_clear: assert property (pready && !pwrite && paddr == ADDR_BUFFER |=> !receive_flag)
      else $error("flag kept after read");
   a_flag_cause: assert property ($rose(receive_flag) |-> $past(receiver_hold))
      else $error("flag without cause");
   a_hold_fall: assert property ($fell(receiver_hold) |-> receive_flag || (pready && pwrite))
      else $error("hold dropped early");
endmodule : rate_detect_chk
`default_nettype wire

//--- bench/serial_src.sv
`timescale 1ns/1ps
`default_nettype none
module serial_src (
   input wire logic clk,
   output var logic line
);
   // line rests high between frames, as a released receive pin does
   initial line = 1'h1;
   task automatic bits(input logic [15:0] v, input int n, bt);
      for (int i = 0; i < n; i++)
         repeat (bt) @(posedge clk) line <= v[i];
   endtask : bits
endmodule : serial_src
`default_nettype wire

//--- bench/uart_autobaud_wake_on_break_tb.sv
`timescale 1ns/1ps
`default_nettype none
module uart_autobaud_wake_on_break_tb import rate_detect_pkg::*;;
   localparam int BT = 102;
   logic        clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata;
   logic [7:0]  rx_data = '0;
   logic        pready, pslverr, receive_flag, receiver_hold, rx_line;
   logic [32:0] qe[$], qm[$];
   logic [15:0] cnt;
   int          err_count = 0, total_checks = 0, s;
   always #25 clk = ~clk;
   serial_src u_src (.clk(clk), .line(rx_line));
   rate_detect u_dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_data(rx_data),
      .serial_in_line(rx_line), .receive_flag(receive_flag), .receiver_hold(receiver_hold));
   task automatic check(input string n, input logic [32:0] v, e);
      total_checks++;
      if (v !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", n, e, v);
      end
   endtask : check
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [32:0] e = '0, m = '1);
      if (!w) begin
         qe.push_back(e);
         qm.push_back(m);
      end
      // start after a rising edge, one idle cycle after any earlier release
      @(posedge clk);
      psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk) penable <= 1'h1;
      do @(posedge clk); while (pready !== 1'h1);
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb
   // reads are judged at the answer, apart from the driver
   always @(negedge clk) if (pready && !pwrite && qe.size() > 0)
      check("read", {pslverr, prdata} & qm.pop_front(), qe.pop_front());
   task automatic wait_flag;
      for (int i = 0; i < 3000 && receive_flag !== 1'h1; i++) @(negedge clk);
      check("receive_flag", receive_flag, 1'h1);
   endtask : wait_flag
   task automatic end_sim;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : end_sim
   initial begin
      repeat (40000) @(posedge clk);
      err_count++;
      end_sim;
   end
   initial begin
      s = $urandom(82681);
      repeat (6) @(posedge clk);
      reset <= 1'h0;
      @(posedge clk);
      apb(0, ADDR_STATUS, 0);
      apb(0, 12'h040, 0, 33'h100000000);
      for (int m = 0; m < 4; m++) begin
         cnt = 16'(1 + 8 * BT / ((m == 0) ? 512 : (m == 3) ? 32 : 128));
         rx_data <= 8'($urandom);
         apb(1, ADDR_CONTROL, (32'(m[1]) << CTL_WIDE_DIVISOR) | (32'(m[0]) << CTL_HIGH_SPEED) | 32'h1);
         @(negedge clk) check("hold", receiver_hold, 1'h1);
         u_src.bits({1'h1, 8'h55, 1'h0}, 10, BT);
         wait_flag;
         apb(0, ADDR_CONTROL, 0, 33'h0, 33'h81);
         apb(0, ADDR_DIV_LOW, 0, 33'(cnt[7:0]), 33'hFF);
         apb(0, ADDR_DIV_HIGH, 0, 33'(cnt[15:8]), 33'hFF);
         apb(0, ADDR_BUFFER, 0, 33'h0, 33'h0);
         @(negedge clk) check("flag", receive_flag, 1'h0);
      end
      apb(1, ADDR_CONTROL, 32'h10B);
      @(negedge clk) check("hold", receiver_hold, 1'h1);
      fork
         u_src.bits(16'h0, 13, BT);
         begin
            repeat (8) @(negedge clk);
            check("wake", receive_flag, 1'h1);
         end
      join
      u_src.bits(16'hFFFF, 3, BT);
      apb(0, ADDR_CONTROL, 0, 33'h1, 33'h3);
      apb(0, ADDR_BUFFER, 0, 33'h0, 33'h0);
      @(negedge clk) check("flag", receive_flag, 1'h0);
      u_src.bits({1'h1, 8'h55, 1'h0}, 10, BT);
      wait_flag;
      apb(0, ADDR_DIV_LOW, 0, 33'(1 + 8 * BT / 32), 33'hFF);
      apb(0, ADDR_BUFFER, 0, 33'h0, 33'h0);
      apb(1, ADDR_CONTROL, 32'h200);
      apb(1, ADDR_CONTROL, 32'h202);
      apb(0, ADDR_CONTROL, 0, 33'h200, 33'h203);
      apb(0, ADDR_CONTROL, 0, 33'h40, 33'h40);
      end_sim;
   end
endmodule : uart_autobaud_wake_on_break_tb
bind rate_detect rate_detect_chk u_chk (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .serial_in_line(serial_in_line), .rx_data(rx_data), .receive_flag(receive_flag), .receiver_hold(receiver_hold));
`default_nettype wire

//--- design/rate_detect.sv
`timescale 1ns/1ps
`default_nettype none
module rate_detect
   import rate_detect_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        serial_in_line,
   input  wire logic [7:0]  rx_data,
   output logic             receive_flag,
   output logic             receiver_hold
);
   typedef struct packed {
      logic        sync1;
      logic        sync2;
      logic        line_prev;
      rate_state_t state;
      logic        auto_rate_enable;
      logic        wake_on_break_enable;
      logic        wake_low_seen;
      logic        wide_divisor_select;
      logic        high_speed_select;
      logic        sync_mode;
      logic        rate_count_overflow;
      logic        receive_flag;
      logic [15:0] divisor;
      logic [8:0]  prescale;
      logic [2:0]  rises;
      logic [31:0] rdata;
      logic        ready;
      logic        err;
   } state_t;

   state_t cur_ff;
   state_t nxt_cur;

   logic       access;
   logic       wr;
   logic       rd;
   logic       rise;
   logic       fall;
   logic       tick;
   logic [8:0] div_top;
   logic       mapped;

   always_comb begin
      access  = psel && penable && !cur_ff.ready;
      wr      = access && pwrite;
      rd      = access && !pwrite;
      rise    = cur_ff.sync2 && !cur_ff.line_prev;
      fall    = !cur_ff.sync2 && cur_ff.line_prev;
      mapped  = (paddr == ADDR_CONTROL) || (paddr == ADDR_DIV_LOW) || (paddr == ADDR_DIV_HIGH)
                || (paddr == ADDR_BUFFER) || (paddr == ADDR_STATUS);
      // tick once per 512, 128 or 32 base clocks, chosen by the two select bits
      case ({cur_ff.wide_divisor_select, cur_ff.high_speed_select})
         2'b00:   div_top = DIV_CLK_512;
         2'b11:   div_top = DIV_CLK_32;
         default: div_top = DIV_CLK_128;
      endcase
      tick = (cur_ff.prescale == div_top);
   end

   always_comb begin
      nxt_cur           = cur_ff;
      nxt_cur.sync1     = serial_in_line;
      nxt_cur.sync2     = cur_ff.sync1;
      nxt_cur.line_prev = cur_ff.sync2;
      nxt_cur.ready     = access;
      nxt_cur.err       = access && !mapped;

      // register writes first so hardware events below win over them
      if (wr) begin
         case (paddr)
            ADDR_CONTROL: begin
               nxt_cur.auto_rate_enable     = pwdata[CTL_AUTO_RATE_ENABLE];
               nxt_cur.wake_on_break_enable = pwdata[CTL_WAKE_ENABLE] && !cur_ff.sync_mode;
               nxt_cur.wide_divisor_select  = pwdata[CTL_WIDE_DIVISOR];
               nxt_cur.high_speed_select    = pwdata[CTL_HIGH_SPEED];
               nxt_cur.sync_mode            = pwdata[CTL_SYNC_MODE];
               // clear only honoured once enable already clear
               if (!pwdata[CTL_OVERFLOW] && !cur_ff.auto_rate_enable)
                  nxt_cur.rate_count_overflow = 1'b0;
               if (pwdata[CTL_WAKE_ENABLE])
                  nxt_cur.wake_low_seen = 1'b0;
               if (pwdata[CTL_AUTO_RATE_ENABLE] && !cur_ff.auto_rate_enable) begin
                  nxt_cur.state = ST_WAIT_START;
                  nxt_cur.rises = 3'h0;
               end
               if (!pwdata[CTL_AUTO_RATE_ENABLE])
                  nxt_cur.state = ST_IDLE;
            end
            ADDR_DIV_LOW:  nxt_cur.divisor[7:0]  = pwdata[7:0];
            ADDR_DIV_HIGH: nxt_cur.divisor[15:8] = pwdata[7:0];
            default: ;
         endcase
      end
      if (rd && paddr == ADDR_BUFFER)
         nxt_cur.receive_flag = 1'b0;

      // wake watch: falling edge wakes, next rise ends break
      if (cur_ff.wake_on_break_enable) begin
         if (fall && !cur_ff.wake_low_seen) begin
            nxt_cur.receive_flag  = 1'b1;
            nxt_cur.wake_low_seen = 1'b1;
         end
         if (rise && cur_ff.wake_low_seen) begin
            nxt_cur.wake_on_break_enable = 1'b0;
            nxt_cur.wake_low_seen        = 1'b0;
         end
      end

      // measurement waits while wake is armed
      if (cur_ff.auto_rate_enable && !cur_ff.wake_on_break_enable) begin
         case (cur_ff.state)
            ST_WAIT_START: begin
               if (fall)
                  nxt_cur.state = ST_WAIT_RISE;
            end
            ST_WAIT_RISE: begin
               if (rise) begin
                  nxt_cur.state    = ST_COUNT;
                  nxt_cur.divisor  = COUNT_START;
                  nxt_cur.prescale = 9'h000;
                  nxt_cur.rises    = 3'h1;
               end
            end
            ST_COUNT: begin
               nxt_cur.prescale = tick ? 9'h000 : cur_ff.prescale + 9'h001;
               if (tick) begin
                  nxt_cur.divisor = cur_ff.divisor + 16'h0001; // wraps, keeps going
                  if (cur_ff.divisor == 16'hFFFF)
                     nxt_cur.rate_count_overflow = 1'b1;
               end
               if (rise) begin
                  nxt_cur.rises = cur_ff.rises + 3'h1;
                  if (cur_ff.rises + 3'h1 == RISES_TO_END) begin
                     nxt_cur.divisor          = cur_ff.divisor;
                     nxt_cur.auto_rate_enable = 1'b0;
                     nxt_cur.receive_flag     = 1'b1;
                     nxt_cur.state            = ST_IDLE;
                  end
               end
            end
            ST_IDLE: ;
            default: nxt_cur.state = ST_IDLE;
         endcase
      end

      nxt_cur.rdata = 32'h0000_0000;
      if (rd) begin
         case (paddr)
            ADDR_CONTROL: begin
               nxt_cur.rdata[CTL_AUTO_RATE_ENABLE] = cur_ff.auto_rate_enable;
               nxt_cur.rdata[CTL_WAKE_ENABLE]      = cur_ff.wake_on_break_enable;
               nxt_cur.rdata[CTL_WIDE_DIVISOR]     = cur_ff.wide_divisor_select;
               // idle when not holding the receiver, or when the synchronised line is high
               nxt_cur.rdata[CTL_RECEIVE_IDLE]     = !(cur_ff.auto_rate_enable || cur_ff.wake_on_break_enable)
                                                     || cur_ff.sync2;
               nxt_cur.rdata[CTL_OVERFLOW]         = cur_ff.rate_count_overflow;
               nxt_cur.rdata[CTL_HIGH_SPEED]       = cur_ff.high_speed_select;
               nxt_cur.rdata[CTL_SYNC_MODE]        = cur_ff.sync_mode;
            end
            ADDR_DIV_LOW:  nxt_cur.rdata[7:0] = cur_ff.divisor[7:0];
            ADDR_DIV_HIGH: nxt_cur.rdata[7:0] = cur_ff.divisor[15:8];
            ADDR_BUFFER:   nxt_cur.rdata[7:0] = rx_data;
            ADDR_STATUS: begin
               nxt_cur.rdata[STS_RECEIVE_FLAG] = cur_ff.receive_flag;
               nxt_cur.rdata[STS_MEASURING]    = cur_ff.state == ST_COUNT;
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cur_ff           <= '0;
         cur_ff.sync1     <= 1'b1;
         cur_ff.sync2     <= 1'b1;
         cur_ff.line_prev <= 1'b1;
         cur_ff.state     <= ST_IDLE;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   always_comb begin
      prdata        = cur_ff.rdata;
      pready        = cur_ff.ready;
      pslverr       = cur_ff.err;
      receive_flag  = cur_ff.receive_flag;
      receiver_hold = cur_ff.auto_rate_enable || cur_ff.wake_on_break_enable;
   end
endmodule : rate_detect
`default_nettype wire

//--- design/rate_detect_pkg.sv
package rate_detect_pkg;
   localparam logic [11:0] ADDR_CONTROL    = 12'h000;
   localparam logic [11:0] ADDR_DIV_LOW    = 12'h004;
   localparam logic [11:0] ADDR_DIV_HIGH   = 12'h008;
   localparam logic [11:0] ADDR_BUFFER     = 12'h00C;
   localparam logic [11:0] ADDR_STATUS     = 12'h010;
   localparam int CTL_AUTO_RATE_ENABLE     = 0;
   localparam int CTL_WAKE_ENABLE          = 1;
   localparam int CTL_WIDE_DIVISOR         = 3;
   localparam int CTL_RECEIVE_IDLE         = 6;
   localparam int CTL_OVERFLOW             = 7;
   localparam int CTL_HIGH_SPEED           = 8;
   localparam int CTL_SYNC_MODE            = 9;
   localparam int STS_RECEIVE_FLAG         = 0;
   localparam int STS_MEASURING            = 1;
   localparam logic [15:0] COUNT_START     = 16'h0001;
   localparam logic [8:0]  DIV_CLK_512     = 9'h1FF;
   localparam logic [8:0]  DIV_CLK_128     = 9'h07F;
   localparam logic [8:0]  DIV_CLK_32      = 9'h01F;
   localparam logic [2:0]  RISES_TO_END    = 3'h5;
   typedef enum logic [1:0] {ST_IDLE, ST_WAIT_START, ST_WAIT_RISE, ST_COUNT} rate_state_t;
endpackage : rate_detect_pkg
